// ==== sir_regs.v ====
// Identification and readback-length bytes with block read and block write sequencing.
// Assumes the serial protocol engine turns bus events into single-cycle strobes on clk.
//
// Summary of operation
// RL1: Low five length bits set block read size; counts above eight still stop a read at nine data bytes.
// RL2: Length resets to eight, nine bytes returned.
// RL3: Upper nibble of identity byte: fixed revision.
// RL4: Lower nibble: fixed maker code, unwritable.
// RL5: Index six returns a fixed part code.
// RL6: Block read sends count, then consecutive bytes.
// RL7: Reserved bytes and bits read zero, ignore writes.
`timescale 1ns/1ps
`include "sir_map.vh"

module sir_regs #(
	parameter [3:0] REV_CODE = 4'h3, // Arbitrary value.
	parameter [3:0] MAKER_CODE = 4'h5, // Arbitrary value.
	parameter [7:0] PART_CODE = 8'h5A // Arbitrary value.
) (
	input wire clk,
	input wire resetn,
	input wire [7:0] start_idx,
	input wire rd_start,
	input wire tx_next,
	input wire tx_end,
	output wire tx_valid,
	output wire [7:0] tx_byte,
	input wire wr_start,
	input wire wr_byte_en,
	input wire [7:0] wr_byte,
	output wire [7:0] low_idx,
	input wire [7:0] low_byte,
	output wire low_wr_en,
	output wire [7:0] low_wr_idx,
	output wire [7:0] low_wr_data,
	output wire [4:0] readback_length,
	output wire busy
);

	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_COUNT = 2'd1;
	localparam [1:0] S_DATA = 2'd2;
	localparam [1:0] S_FILL = 2'd3;

	localparam [1:0] W_IDLE = 2'd0;
	localparam [1:0] W_CNT = 2'd1;
	localparam [1:0] W_DATA = 2'd2;

	reg [1:0] rstate_r;
	reg [1:0] rstate_nxt;
	reg [7:0] ridx_r;
	reg [3:0] rleft_r;
	reg [7:0] tx_byte_r;
	reg tx_valid_r;

	reg [1:0] wstate_r;
	reg [7:0] widx_r;
	reg [7:0] wleft_r;
	reg low_wr_en_r;
	reg [7:0] low_wr_idx_r;
	reg [7:0] low_wr_data_r;

	wire [7:0] bank_rd;
	wire bank_rd_hit;
	wire bank_wr_hit;
	wire [4:0] len_q;
	wire wr_fire;
	wire [4:0] len_use;
	wire [7:0] cur_byte;

	// ----------------------------------------------------------------
	// Byte bank
	// ----------------------------------------------------------------
	assign wr_fire = (wstate_r == W_DATA) && wr_byte_en && (wleft_r != 8'h00);

	sir_bank #(
		.REV_CODE(REV_CODE),
		.MAKER_CODE(MAKER_CODE),
		.PART_CODE(PART_CODE)
	) u_bank (
		.clk(clk),
		.resetn(resetn),
		.wr_en(wr_fire),
		.wr_idx(widx_r),
		.wr_data(wr_byte),
		.rd_idx(ridx_r),
		.rd_data(bank_rd),
		.rd_hit(bank_rd_hit),
		.wr_hit(bank_wr_hit),
		.len_q(len_q)
	);

	// Counts above eight are kept as written but never run a read past nine data bytes after the count byte.
	assign len_use = (len_q > `SIR_LEN_MAX) ? `SIR_LEN_MAX : len_q; // [RL1]
	assign cur_byte = bank_rd_hit ? bank_rd : low_byte;

	// ----------------------------------------------------------------
	// Block read sequencer
	// ----------------------------------------------------------------
	always @* begin
		rstate_nxt = rstate_r;
		case (rstate_r)
			S_IDLE: begin
				if (rd_start) begin
					rstate_nxt = S_COUNT;
				end
			end
			S_COUNT, S_DATA: begin
				if (tx_end) begin
					rstate_nxt = S_IDLE;
				end else if (tx_next) begin
					rstate_nxt = (rleft_r != 4'h0) ? S_DATA : S_FILL;
				end
			end
			S_FILL: begin
				if (tx_end) begin
					rstate_nxt = S_IDLE;
				end
			end
			default: begin
				rstate_nxt = S_IDLE;
			end
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstate_r <= S_IDLE;
			ridx_r <= 8'h00;
			rleft_r <= 4'h0;
			tx_byte_r <= 8'h00;
			tx_valid_r <= 1'b0;
		end else begin
			rstate_r <= rstate_nxt;
			case (rstate_r)
				S_IDLE: begin
					if (rd_start) begin
						// The count byte leads every block read. [RL6]
						tx_byte_r <= {3'h0, len_q};
						tx_valid_r <= 1'b1;
						ridx_r <= start_idx;
						rleft_r <= len_use[3:0] + 4'h1; // [RL2]
					end
				end
				S_COUNT, S_DATA: begin
					if (tx_end) begin
						tx_valid_r <= 1'b0;
					end else if (tx_next) begin
						if (rleft_r != 4'h0) begin
							tx_byte_r <= cur_byte; // [RL6]
							ridx_r <= ridx_r + 8'h01;
							rleft_r <= rleft_r - 4'h1;
						end else begin
							// The host overran the count; pad rather than wrap the index.
							tx_byte_r <= `SIR_BYTE_ZERO;
						end
					end
				end
				S_FILL: begin
					if (tx_end) begin
						tx_valid_r <= 1'b0;
					end
				end
				default: begin
					tx_valid_r <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Block write sequencer
	// ----------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wstate_r <= W_IDLE;
			widx_r <= 8'h00;
			wleft_r <= 8'h00;
			low_wr_en_r <= 1'b0;
			low_wr_idx_r <= 8'h00;
			low_wr_data_r <= 8'h00;
		end else begin
			low_wr_en_r <= 1'b0;
			case (wstate_r)
				W_IDLE: begin
					if (wr_start) begin
						widx_r <= start_idx;
						wstate_r <= W_CNT;
					end
				end
				W_CNT: begin
					if (tx_end) begin
						wstate_r <= W_IDLE;
					end else if (wr_byte_en) begin
						wleft_r <= wr_byte;
						wstate_r <= W_DATA;
					end
				end
				W_DATA: begin
					if (tx_end) begin
						wstate_r <= W_IDLE;
					end else if (wr_fire) begin
						// Bytes outside this bank are handed to the lower control bytes.
						if (!bank_wr_hit) begin
							low_wr_en_r <= 1'b1;
							low_wr_idx_r <= widx_r;
							low_wr_data_r <= wr_byte;
						end
						widx_r <= widx_r + 8'h01;
						wleft_r <= wleft_r - 8'h01;
					end
				end
				default: begin
					wstate_r <= W_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign tx_valid = tx_valid_r;
	assign tx_byte = tx_byte_r;
	assign low_idx = ridx_r;
	assign low_wr_en = low_wr_en_r;
	assign low_wr_idx = low_wr_idx_r;
	assign low_wr_data = low_wr_data_r;
	assign readback_length = len_q;
	assign busy = (rstate_r != S_IDLE) || (wstate_r != W_IDLE);

endmodule

// ==== sir_map.vh ====
// Index map, field positions and reset values of the identification and count bytes.
// Assumes byte indices are eight bits wide, as issued by the serial protocol engine.
`ifndef SIR_MAP_VH
`define SIR_MAP_VH

// ----------------------------------------------------------------
// Byte indices
// ----------------------------------------------------------------
`define SIR_IDX_SPARE_A 8'h04
`define SIR_IDX_IDENT 8'h05
`define SIR_IDX_PART 8'h06
`define SIR_IDX_LEN 8'h07
`define SIR_IDX_SPARE_B 8'h08
`define SIR_IDX_FIRST 8'h04
`define SIR_IDX_LAST 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SIR_REV_MSB 7
`define SIR_REV_LSB 4
`define SIR_MAKER_MSB 3
`define SIR_MAKER_LSB 0
`define SIR_LEN_MSB 4
`define SIR_LEN_LSB 0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SIR_LEN_RST 5'h08
`define SIR_LEN_MAX 5'h08
`define SIR_BYTE_ZERO 8'h00

`endif

// ==== sir_bank.v ====
// Byte bank for indices 4 to 8: spare bytes, identification bytes and the readback length.
// Assumes writes arrive as single-cycle strobes synchronous to clk.
`timescale 1ns/1ps
`include "sir_map.vh"

module sir_bank #(
	parameter [3:0] REV_CODE = 4'h3, // Arbitrary value.
	parameter [3:0] MAKER_CODE = 4'h5, // Arbitrary value.
	parameter [7:0] PART_CODE = 8'h5A // Arbitrary value.
) (
	input wire clk,
	input wire resetn,
	input wire wr_en,
	input wire [7:0] wr_idx,
	input wire [7:0] wr_data,
	input wire [7:0] rd_idx,
	output reg [7:0] rd_data,
	output wire rd_hit,
	output wire wr_hit,
	output wire [4:0] len_q
);

	reg [4:0] len_r;

	// ----------------------------------------------------------------
	// Index decode
	// ----------------------------------------------------------------
	function in_bank;
		input [7:0] idx;
		begin
			in_bank = (idx >= `SIR_IDX_FIRST) && (idx <= `SIR_IDX_LAST);
		end
	endfunction

	assign rd_hit = in_bank(rd_idx);
	assign wr_hit = in_bank(wr_idx);
	assign len_q = len_r;

	// Only the length field is storage; writes elsewhere in the bank are dropped. [RL4] [RL7]
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			len_r <= `SIR_LEN_RST; // [RL2]
		end else if (wr_en && wr_hit && (wr_idx == `SIR_IDX_LEN)) begin
			len_r <= wr_data[`SIR_LEN_MSB:`SIR_LEN_LSB]; // [RL1]
		end
	end

	always @* begin
		rd_data = `SIR_BYTE_ZERO; // [RL7]
		case (rd_idx)
			`SIR_IDX_IDENT: begin
				rd_data[`SIR_REV_MSB:`SIR_REV_LSB] = REV_CODE; // [RL3]
				rd_data[`SIR_MAKER_MSB:`SIR_MAKER_LSB] = MAKER_CODE; // [RL4]
			end
			`SIR_IDX_PART: begin
				rd_data = PART_CODE; // [RL5]
			end
			`SIR_IDX_LEN: begin
				rd_data[`SIR_LEN_MSB:`SIR_LEN_LSB] = len_r; // [RL1]
			end
			default: begin
				rd_data = `SIR_BYTE_ZERO; // [RL7]
			end
		endcase
	end

endmodule

// ==== sir_regs_props.sv ====
// Checker for the identification and count bytes.
// Assumes it is bound to sir_regs and sees only its ports.
`timescale 1ns/1ps
module sir_regs_props #(
	parameter [3:0] REV_CODE = 4'h3, // Arbitrary value.
	parameter [3:0] MAKER_CODE = 4'h5, // Arbitrary value.
	parameter [7:0] PART_CODE = 8'h5A // Arbitrary value.
) (
	input wire clk,
	input wire resetn,
	input wire [7:0] start_idx,
	input wire rd_start,
	input wire tx_next,
	input wire tx_end,
	input wire tx_valid,
	input wire [7:0] tx_byte,
	input wire low_wr_en,
	input wire [7:0] low_wr_idx,
	input wire [4:0] readback_length,
	input wire busy
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
sequence s_go(i);
	rd_start && !busy && start_idx == i ##1 tx_next;
endsequence
property p_rst; $rose(resetn) |-> readback_length == 5'h08; endproperty
property p_count; rd_start && !busy |=> tx_byte == {3'h0, $past(readback_length)}; endproperty
property p_ident; s_go(8'h05) |=> tx_byte == {REV_CODE, MAKER_CODE}; endproperty
property p_part; s_go(8'h06) |=> tx_byte == PART_CODE; endproperty
property p_spare; s_go(8'h04) |=> tx_byte == 8'h00; endproperty
property p_end; tx_end |=> !tx_valid; endproperty
property p_busy; rd_start |=> busy && tx_valid; endproperty
property p_low; low_wr_en |-> low_wr_idx < 8'h04 || low_wr_idx > 8'h08; endproperty
a_rst: assert property (p_rst) else $error("length not eight after reset");
a_count: assert property (p_count) else $error("bad count byte");
a_ident: assert property (p_ident) else $error("bad ident byte");
a_part: assert property (p_part) else $error("bad part byte");
a_spare: assert property (p_spare) else $error("spare byte not zero");
a_end: assert property (p_end) else $error("read not ended");
a_busy: assert property (p_busy) else $error("read not started");
a_low: assert property (p_low) else $error("bank index leaked");
c_read: cover property (s_go(8'h05));
c_write: cover property (low_wr_en);
c_end: cover property (tx_valid && tx_end);
endmodule
bind sir_regs sir_regs_props #(.REV_CODE(REV_CODE), .MAKER_CODE(MAKER_CODE),
	.PART_CODE(PART_CODE)) i_props (.clk(clk), .resetn(resetn), .start_idx(start_idx),
	.rd_start(rd_start), .tx_next(tx_next), .tx_end(tx_end), .tx_valid(tx_valid),
	.tx_byte(tx_byte), .low_wr_en(low_wr_en), .low_wr_idx(low_wr_idx),
	.readback_length(readback_length), .busy(busy));

// ==== sir_host.sv ====
// Host controller stand-in issuing block reads and writes as strobes.
// Assumes strobes are taken on the rising edge and changed 1 ns after it.
`timescale 1ns/1ps
module sir_host (
	input wire clk,
	input wire tx_valid,
	input wire [7:0] tx_byte,
	input wire [7:0] low_idx,
	output wire [7:0] low_byte,
	output logic [7:0] start_idx,
	output logic rd_start,
	output logic tx_next,
	output logic tx_end,
	output logic wr_start,
	output logic wr_byte_en,
	output logic [7:0] wr_byte
);
logic [7:0] got [0:15];
// Lower bank stand-in: each index returns its own inverse.
assign low_byte = ~low_idx;
initial begin
	{start_idx, rd_start, tx_next, tx_end, wr_start, wr_byte_en, wr_byte} = 0;
end
task automatic rd(input logic [7:0] i, input int n);
	@(posedge clk) #1;
	start_idx = i;
	rd_start = 1;
	for (int k = 0; k < n; k++) begin
		@(posedge clk) #1;
		rd_start = 0;
		start_idx = ~i;
		got[k] = tx_valid ? tx_byte : 8'hXX;
		tx_next = k < n - 1;
		tx_end = k == n - 1;
	end
	@(posedge clk) #1;
	{tx_next, tx_end} = 0;
endtask
task automatic wr(input logic [7:0] i, x, input int m, input logic [31:0] d);
	@(posedge clk) #1;
	start_idx = i;
	wr_start = 1;
	@(posedge clk) #1;
	{wr_start, wr_byte_en, wr_byte} = {2'b01, x};
	for (int k = 0; k < m; k++) begin
		@(posedge clk) #1;
		wr_byte = d[8*k+:8];
	end
	@(posedge clk) #1;
	{wr_byte_en, tx_end, wr_byte, start_idx} = {2'b01, ~wr_byte, ~i};
	@(posedge clk) #1;
	tx_end = 0;
endtask
endmodule

// ==== sir_regs_bench.sv ====
// Bench for the identification and count bytes.
// Assumes the host model drives every strobe of the design.
`timescale 1ns/1ps
module sir_regs_bench;
localparam [3:0] REV = 4'h3; // Arbitrary code.
localparam [3:0] MAKER = 4'h5; // Arbitrary code.
localparam [7:0] PART = 8'h5A; // Arbitrary code.
logic clk = 0;
logic resetn = 0;
wire [7:0] start_idx, tx_byte, wr_byte, low_idx, low_byte, low_wr_idx, low_wr_data;
wire rd_start, tx_next, tx_end, tx_valid, wr_start, wr_byte_en, low_wr_en, busy;
wire [4:0] readback_length;
int n_errors = 0;
int check_count = 0;
always #5 clk = ~clk;
sir_regs #(.REV_CODE(REV), .MAKER_CODE(MAKER), .PART_CODE(PART)) i_dut (.clk(clk),
	.resetn(resetn), .start_idx(start_idx), .rd_start(rd_start), .tx_next(tx_next),
	.tx_end(tx_end), .tx_valid(tx_valid), .tx_byte(tx_byte), .wr_start(wr_start),
	.wr_byte_en(wr_byte_en), .wr_byte(wr_byte), .low_idx(low_idx), .low_byte(low_byte),
	.low_wr_en(low_wr_en), .low_wr_idx(low_wr_idx), .low_wr_data(low_wr_data),
	.readback_length(readback_length), .busy(busy));
sir_host i_host (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte), .low_idx(low_idx),
	.low_byte(low_byte), .start_idx(start_idx), .rd_start(rd_start), .tx_next(tx_next),
	.tx_end(tx_end), .wr_start(wr_start), .wr_byte_en(wr_byte_en), .wr_byte(wr_byte));
function automatic logic [7:0] expb(input logic [7:0] i, input logic [4:0] len);
	case (i)
	8'h04, 8'h08: expb = 8'h00;
	8'h05: expb = {REV, MAKER};
	8'h06: expb = PART;
	8'h07: expb = {3'h0, len};
	default: expb = ~i;
	endcase
endfunction
task automatic chk(input logic [7:0] seen, input logic [7:0] want);
	check_count++;
	if (seen !== want) begin
		n_errors++;
		$display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
	end
endtask
task automatic rdchk(input logic [7:0] i, input logic [4:0] len);
	i_host.rd(i, len + 2);
	chk(i_host.got[0], {3'h0, len});
	for (int k = 0; k <= len; k++) begin
		chk(i_host.got[k + 1], expb(i + 8'(k), len));
	end
endtask
task automatic test_done;
	$display("errors=%0d checks=%0d", n_errors, check_count);
	if (n_errors == 0 && check_count > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
initial begin
	repeat (2) @(posedge clk);
	#1 resetn = 1;
	chk({3'h0, readback_length}, 8'h08);
	rdchk(8'h04, 5'h08);
	i_host.wr(8'h05, 8'h03, 3, 32'h00E3FFFF);
	chk({3'h0, readback_length}, 8'h03);
	chk({7'h0, busy}, 8'h00);
	rdchk(8'h05, 5'h03);
	i_host.wr(8'h02, 8'h01, 2, 32'h000077AA);
	chk(low_wr_idx, 8'h02);
	chk(low_wr_data, 8'hAA);
	i_host.wr(8'h07, 8'h01, 1, 32'h00000000);
	i_host.wr(8'h08, 8'h01, 1, 32'h000000FF);
	rdchk(8'h08, 5'h00);
	i_host.wr(8'h07, 8'h01, 1, 32'h0000000C);
	i_host.rd(8'h04, 12);
	chk(i_host.got[0], 8'h0C);
	for (int k = 1; k < 12; k++) begin
		chk(i_host.got[k], (k < 10) ? expb(8'h03 + 8'(k), 5'h0C) : 8'h00);
	end
	resetn = 0;
	#20 resetn = 1;
	chk({3'h0, readback_length}, 8'h08);
	rdchk(8'h06, 5'h08);
	test_done();
end
initial begin
	#20000;
	n_errors++;
	test_done();
end
endmodule
